// ==== hw/pmsc_top.sv ====
// AXI4-Lite power management control register with interrupt
`include "pmsc_consts.svh"
module pmsc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic porRst_n,
  input wire logic deepStopWake,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic detectTripSelect,
  output logic warningTripSelect,
  output logic stopDepthSelect,
  output pmsc_pkg::pmsc_stop_t stopMode,
  output logic irq
);
  // ****************************************
  // Write channel capture
  // ****************************************
  logic awHeld, wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic wakeSync1, wakeSync2, wakeLast;
  logic wakeEvent;
  logic flag;
  logic [`PMSC_IRQ_WIDTH-1:0] irqStatus, irqEnable, irqClearMask, irqSet;
  logic detectLocked, depthLocked, detectIgnored, depthIgnored;
  logic ctrlWr, lowLane;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      awAddr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMSC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr[1:0] == 2'b00) ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Byte lane 0 holds the whole 8-bit register; other lanes have no storage
  assign lowLane = wStrb[0];
  assign ctrlWr = doWrite && (awAddr == `PMSC_ADDR_CTRL) && lowLane;
  // ****************************************
  // Write-once bits and the warning select
  // ****************************************
  // Detect select lock survives every reset but power-on
  pmsc_once_bit #(.RESET_VALUE(`PMSC_RESET_DETECT)) uDetect ( // see R1
    .mclk(mclk),
    .rstLockN(porRst_n), // see R6
    .rstValN(porRst_n), // see R10
    .wrEn(ctrlWr),
    .wrData(wData[`PMSC_BIT_DETECT]),
    .value(detectTripSelect),
    .locked(detectLocked),
    .wrIgnored(detectIgnored)
  );
  pmsc_once_bit #(.RESET_VALUE(`PMSC_RESET_DEPTH)) uDepth ( // see R5
    .mclk(mclk),
    .rstLockN(arst_n), // see R7
    .rstValN(arst_n), // see R10
    .wrEn(ctrlWr),
    .wrData(wData[`PMSC_BIT_DEPTH]),
    .value(stopDepthSelect),
    .locked(depthLocked),
    .wrIgnored(depthIgnored)
  );
  assign stopMode = stopDepthSelect ? pmsc_pkg::PMSC_STOP_PARTIAL : pmsc_pkg::PMSC_STOP_RETAIN; // see R5
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      warningTripSelect <= `PMSC_RESET_WARN;
    end else if (ctrlWr) begin
      warningTripSelect <= wData[`PMSC_BIT_WARN]; // see R2
    end
  end
  // ****************************************
  // Recovery flag
  // ****************************************
  // Wake comes from the power controller, outside this clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wakeSync1 <= 1'b0;
      wakeSync2 <= 1'b0;
      wakeLast <= 1'b0;
    end else begin
      wakeSync1 <= deepStopWake;
      wakeSync2 <= wakeSync1;
      wakeLast <= wakeSync2;
    end
  end
  assign wakeEvent = wakeSync2 && !wakeLast;
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge porRst_n) begin
    if (!porRst_n) begin
      flag <= 1'b0;
    end else if (wakeEvent) begin
      flag <= 1'b1; // see R3
    end else if (ctrlWr && wData[`PMSC_BIT_CLEAR]) begin
      flag <= 1'b0; // see R4, see R9
    end
  end
  // ****************************************
  // Interrupt registers
  // ****************************************
  assign irqSet = {(detectIgnored || depthIgnored), wakeEvent};
  assign irqClearMask = (doWrite && awAddr == `PMSC_ADDR_IRQ_CLEAR && lowLane) ?
    wData[`PMSC_IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqStatus & ~irqClearMask) | irqSet;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnable <= '0;
    end else if (doWrite && awAddr == `PMSC_ADDR_IRQ_ENABLE && lowLane) begin
      irqEnable <= wData[`PMSC_IRQ_WIDTH-1:0];
    end
  end
  assign irq = |(irqStatus & irqEnable);
  // ****************************************
  // Read channel
  // ****************************************
  function automatic logic [31:0] readValue(input logic [3:0] addr);
    logic [31:0] v;
    v = 32'h0;
    case (addr)
      `PMSC_ADDR_CTRL: begin
        v[`PMSC_BIT_DETECT] = detectTripSelect;
        v[`PMSC_BIT_WARN] = warningTripSelect;
        v[`PMSC_BIT_FLAG] = flag; // see R3
        v[`PMSC_BIT_CLEAR] = 1'b0; // see R9
        v[`PMSC_BIT_DEPTH] = stopDepthSelect;
      end
      `PMSC_ADDR_IRQ_STATUS: v[`PMSC_IRQ_WIDTH-1:0] = irqStatus;
      `PMSC_ADDR_IRQ_ENABLE: v[`PMSC_IRQ_WIDTH-1:0] = irqEnable;
      default: v = 32'h0;
    endcase
    return v;
  endfunction
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PMSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readValue(s_axi_araddr);
      s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00) ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_detect_locked_hold: assert property (@(posedge mclk) disable iff (!porRst_n || !arst_n) // see R6
    detectLocked && ctrlWr |=> $stable(detectTripSelect))
    else $error("detect select changed after lock");
  a_depth_locked_hold: assert property (@(posedge mclk) disable iff (!arst_n) // see R7
    depthLocked && ctrlWr |=> $stable(stopDepthSelect))
    else $error("stop depth changed after lock");
  a_depth_first_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    !depthLocked && ctrlWr |=> stopDepthSelect == $past(wData[`PMSC_BIT_DEPTH]) && depthLocked)
    else $error("first depth write not taken");
  a_detect_first_write: assert property (@(posedge mclk) disable iff (!porRst_n || !arst_n) // see R1
    !detectLocked && ctrlWr |=> detectTripSelect == $past(wData[`PMSC_BIT_DETECT]))
    else $error("first detect write not taken");
  a_warn_follows_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R2
    ctrlWr |=> warningTripSelect == $past(wData[`PMSC_BIT_WARN]))
    else $error("warning select not written");
  a_flag_set_wake: assert property (@(posedge mclk) disable iff (!porRst_n || !arst_n) // see R3
    wakeEvent |=> flag)
    else $error("wake did not set flag");
  a_flag_clear_ack: assert property (@(posedge mclk) disable iff (!porRst_n || !arst_n) // see R4
    ctrlWr && wData[`PMSC_BIT_CLEAR] && !wakeEvent |=> !flag)
    else $error("acknowledge did not clear flag");
  a_flag_zero_ack: assert property (@(posedge mclk) disable iff (!porRst_n || !arst_n) // see R9
    flag && !(ctrlWr && wData[`PMSC_BIT_CLEAR]) |=> flag)
    else $error("flag lost without acknowledge");
  a_clear_reads_zero: assert property (@(posedge mclk) disable iff (!arst_n) // see R9
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `PMSC_ADDR_CTRL |=> !s_axi_rdata[`PMSC_BIT_CLEAR])
    else $error("clear bit read nonzero");
  // Enable writes in the same cycle may drop the mask, so they are left out
  a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
    wakeEvent && irqEnable[`PMSC_IRQ_BIT_WAKE] && !(doWrite && awAddr == `PMSC_ADDR_IRQ_ENABLE) |=> irq)
    else $error("interrupt output wrong");
  a_ignored_status: assert property (@(posedge mclk) disable iff (!arst_n) // see R6
    (detectIgnored || depthIgnored) |=> irqStatus[`PMSC_IRQ_BIT_LOCKVIOL])
    else $error("ignored write not reported");
  a_wake_status: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wakeEvent |=> irqStatus[`PMSC_IRQ_BIT_WAKE])
    else $error("wake not reported in status");
  c_depth_written: cover property (@(posedge mclk) disable iff (!arst_n) ctrlWr && !depthLocked);
  c_write_ignored: cover property (@(posedge mclk) disable iff (!arst_n) depthIgnored);
  c_wake_then_ack: cover property (@(posedge mclk) disable iff (!arst_n)
    wakeEvent ##[1:20] (ctrlWr && wData[`PMSC_BIT_CLEAR]));
  c_irq_raised: cover property (@(posedge mclk) disable iff (!arst_n) $rose(irq));
  c_flag_cleared: cover property (@(posedge mclk) disable iff (!porRst_n) $fell(flag));
endmodule

// ==== hw/pmsc_consts.svh ====
// Constants for the power management stop and undervoltage control block
// Behaviour
// R1 - Bit 5 is a write-once detect trip select that also picks the warning threshold range.
// R2 - Bit 4 selects the warning comparator trip point within the range chosen by bit 5.
// R3 - Bit 3 is a read-only flag that reads 1 after waking from partial power down stop, else 0.
// R4 - Writing a one to bit 2 clears the partial power down recovery flag.
// R5 - Bit 0 is a write-once stop depth select: 0 state-retaining stop, 1 partial power down stop.
// R6 - One write-once bit takes only the first write after power-on reset and ignores later ones.
// R7 - The other write-once bit takes only the first write after any reset and ignores later ones.
// R8 - Software should write this register during reset initialisation, even with reset values.
// R9 - The clear bit always reads zero, and writing zero to it leaves the flag unchanged.
// R10 - The detect select locks until power-on reset, the stop depth select until any reset.
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH
// ****************************************
// Addresses
// ****************************************
`define PMSC_ADDR_CTRL 4'h0
`define PMSC_ADDR_IRQ_STATUS 4'h4
`define PMSC_ADDR_IRQ_CLEAR 4'h8
`define PMSC_ADDR_IRQ_ENABLE 4'hc
// ****************************************
// Fields
// ****************************************
`define PMSC_BIT_DETECT 5
`define PMSC_BIT_WARN 4
`define PMSC_BIT_FLAG 3
`define PMSC_BIT_CLEAR 2
`define PMSC_BIT_DEPTH 0
`define PMSC_RESET_DETECT 1'b0
`define PMSC_RESET_WARN 1'b0
`define PMSC_RESET_DEPTH 1'b0
`define PMSC_IRQ_BIT_WAKE 0
`define PMSC_IRQ_BIT_LOCKVIOL 1
`define PMSC_IRQ_WIDTH 2
`define PMSC_RESP_OKAY 2'b00
`define PMSC_RESP_SLVERR 2'b10
`endif

// ==== hw/pmsc_pkg.sv ====
// Types for the power management stop and undervoltage control block
package pmsc_pkg;
  typedef enum logic [1:0] {
    PMSC_STOP_RETAIN = 2'b01,
    PMSC_STOP_PARTIAL = 2'b10
  } pmsc_stop_t;
endpackage

// ==== hw/pmsc_once_bit.sv ====
// Write-once control bit with lock
module pmsc_once_bit #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic mclk,
  input wire logic rstLockN,
  input wire logic rstValN,
  input wire logic wrEn,
  input wire logic wrData,
  output logic value,
  output logic locked,
  output logic wrIgnored
);
  // Value and lock may clear on different resets
  always_ff @(posedge mclk or negedge rstValN) begin
    if (!rstValN) begin
      value <= RESET_VALUE;
    end else if (wrEn && !locked) begin
      value <= wrData;
    end
  end
  always_ff @(posedge mclk or negedge rstLockN) begin
    if (!rstLockN) begin
      locked <= 1'b0;
    end else if (wrEn) begin
      locked <= 1'b1;
    end
  end
  assign wrIgnored = wrEn && locked;
endmodule

// ==== test/pmsc_top_bench.sv ====
// Self-checking bench for the power management control register block
`include "pmsc_consts.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", what, exp, got); end end
module pmsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'b0, arst_n = 1'b0, porRst_n = 1'b0, deepStopWake = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic detectTripSelect, warningTripSelect, stopDepthSelect, irq;
  pmsc_pkg::pmsc_stop_t stopMode;
  int miscompares = 0, cmp_count = 0, cycles = 0, seed = 38;
  // Model state kept as plain integers
  int mDetect, mWarn, mFlag, mDepth, lockD, lockP, mStat;
  logic [31:0] d, rd;
  logic [1:0] rs;
  always #10 mclk = ~mclk;
  pmsc_top uut (.mclk(mclk), .arst_n(arst_n), .porRst_n(porRst_n), .deepStopWake(deepStopWake),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .detectTripSelect(detectTripSelect),
    .warningTripSelect(warningTripSelect), .stopDepthSelect(stopDepthSelect), .stopMode(stopMode),
    .irq(irq));
  // ****************************************
  // Closing and timeout
  // ****************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] r);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (!awDone && s_axi_awready) begin awDone = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!wDone && s_axi_wready) begin wDone = 1'b1; s_axi_wvalid <= 1'b0; end
      if (s_axi_bvalid) begin r = s_axi_bresp; s_axi_bready <= 1'b0; break; end
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    logic aDone;
    aDone = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (!aDone && s_axi_arready) begin aDone = 1'b1; s_axi_arvalid <= 1'b0; end
      if (s_axi_rvalid) begin v = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; break; end
    end
  endtask
  // ****************************************
  // Model and checks
  // ****************************************
  task automatic wr_ctrl(input logic [31:0] v);
    axi_write(`PMSC_ADDR_CTRL, v, 4'hf, rs);
    `CHK("ctrl bresp", `PMSC_RESP_OKAY, rs)
    if (lockD != 0 || lockP != 0) mStat |= 2;
    if (lockD == 0) mDetect = v[5];
    if (lockP == 0) mDepth = v[0];
    mWarn = v[4];
    if (v[2]) mFlag = 0;
    lockD = 1;
    lockP = 1;
  endtask
  task automatic chk_ctrl();
    logic [31:0] ex;
    ex = {26'h0, 1'(mDetect), 1'(mWarn), 1'(mFlag), 3'(mDepth)};
    axi_read(`PMSC_ADDR_CTRL, rd, rs);
    `CHK("ctrl", ex, rd)
    `CHK("ports", {ex[5], ex[4], ex[0]}, {detectTripSelect, warningTripSelect, stopDepthSelect})
    `CHK("stopMode", (mDepth != 0) ? pmsc_pkg::PMSC_STOP_PARTIAL : pmsc_pkg::PMSC_STOP_RETAIN, stopMode)
  endtask
  task automatic chk_stat(input logic [31:0] ex);
    axi_read(`PMSC_ADDR_IRQ_STATUS, rd, rs);
    `CHK("irq status", ex, rd)
  endtask
  // General reset always; power-on reset as well when por is set
  task automatic do_reset(input bit por);
    @(posedge mclk);
    arst_n <= 1'b0;
    if (por) porRst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    porRst_n <= 1'b1;
    mDepth = 0; lockP = 0; mWarn = 0; mStat = 0;
    if (por) begin mDetect = 0; lockD = 0; mFlag = 0; end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset(1'b1);
    chk_ctrl();
    // Lane 0 disabled: must not spend the single write
    axi_write(`PMSC_ADDR_CTRL, 32'h31, 4'he, rs);
    chk_ctrl();
    d = $random(seed);
    wr_ctrl(d);
    chk_ctrl();
    wr_ctrl(~d);
    chk_ctrl();
    chk_stat(32'h2);
    axi_write(`PMSC_ADDR_IRQ_ENABLE, 32'h3, 4'hf, rs);
    `CHK("irq on", 1'b1, irq)
    axi_write(`PMSC_ADDR_IRQ_CLEAR, 32'h2, 4'hf, rs);
    chk_stat(32'h0);
    `CHK("irq off", 1'b0, irq)
    // Wake passes a two-flop synchroniser before it is seen
    deepStopWake <= 1'b1;
    repeat (6) @(posedge mclk);
    mFlag = 1;
    chk_stat(32'h1);
    `CHK("irq wake", 1'b1, irq)
    deepStopWake <= 1'b0;
    wr_ctrl(d & ~32'h4);
    chk_ctrl();
    do_reset(1'b0);
    chk_ctrl();
    `CHK("irq rst", 1'b0, irq)
    wr_ctrl({d[31:6], ~d[5], 1'b1, 4'h5});
    chk_ctrl();
    chk_stat(mStat);
    axi_write(4'h1, 32'h0, 4'hf, rs);
    `CHK("bad wr", `PMSC_RESP_SLVERR, rs)
    axi_read(4'h2, rd, rs);
    `CHK("bad rd", `PMSC_RESP_SLVERR, rs)
    chk_ctrl();
    do_reset(1'b1);
    chk_ctrl();
    wr_ctrl({26'h0, ~d[5], 5'h11});
    chk_ctrl();
    end_sim();
  end
endmodule
